// ### rtl/magsense_pkg.sv
package magsense_pkg;
	// ----------------------------------------
	// Register map of the sensor end
	// ----------------------------------------
	localparam logic [7:0] REG_X_UPPER = 8'h00;
	localparam logic [7:0] REG_X_MIDDLE = 8'h01;
	localparam logic [7:0] REG_Y_UPPER = 8'h02;
	localparam logic [7:0] REG_Y_MIDDLE = 8'h03;
	localparam logic [7:0] REG_Z_UPPER = 8'h04;
	localparam logic [7:0] REG_Z_MIDDLE = 8'h05;
	localparam logic [7:0] REG_X_LOW_NIBBLE = 8'h06;
	localparam logic [7:0] REG_Y_LOW_NIBBLE = 8'h07;
	localparam logic [7:0] REG_Z_LOW_NIBBLE = 8'h08;
	localparam logic [7:0] REG_TEMPERATURE = 8'h09;
	localparam logic [7:0] REG_SYNC_PERIOD_LOW = 8'h0A;
	localparam logic [7:0] REG_SYNC_PERIOD_HIGH = 8'h0B;
	localparam logic [7:0] REG_SYNC_TIME_UNIT = 8'h0C;
	localparam logic [7:0] REG_STATUS_FIRST = 8'h18;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// ----------------------------------------
	// Common command defining bytes
	// ----------------------------------------
	localparam logic [7:0] CCC_SYNC_TICK = 8'h7F;
	localparam logic [7:0] CCC_DELAY_TIME = 8'hBF;
	localparam logic [7:0] CCC_SYNC_PERIOD = 8'h3F;
	localparam logic [7:0] CCC_TIME_UNIT = 8'h9F;
	// ----------------------------------------
	// Status flag positions
	// ----------------------------------------
	localparam int ST_MAG_DONE_INT = 0;
	localparam int ST_TEMP_DONE_INT = 1;
	localparam int ST_MOTION_INT = 2;
	localparam int ST_SYNC_ERR = 3;
	localparam int ST_MEM_LOAD_DONE = 4;
	localparam int ST_SELFTEST = 5;
	localparam int ST_MAG_READY = 6;
	localparam int ST_TEMP_READY = 7;
	localparam int STATUS_W = 8;
	// ----------------------------------------
	// Field widths and layouts
	// ----------------------------------------
	localparam int AXIS_W = 20;
	localparam int TEMP_W = 8;
	localparam int PERIOD_W = 10;
	localparam int PERIOD_WIDTH_SEL_BIT = 7;
	localparam int TU_W = 2;
	localparam logic [3:0] TU_BASE_EXP = 4'hB;
	localparam logic [AXIS_W-1:0] MASK_16BIT = 20'hFFFF0;
	localparam logic [AXIS_W-1:0] MASK_18BIT = 20'hFFFFC;
	localparam logic [AXIS_W-1:0] MASK_20BIT = 20'hFFFFF;
	typedef enum logic [1:0] {RES_16 = 2'h0, RES_18 = 2'h1, RES_20 = 2'h2} resolution_e;
	// ----------------------------------------
	// Link frame: ccc flag, command, data, odd parity
	// ----------------------------------------
	localparam int FRAME_BITS = 18;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] FRAME_END_CNT = 5'h12;
	localparam logic [CNT_W-1:0] CMD_DONE_CNT = 5'h09;
	localparam logic [CNT_W-1:0] RD_LAST_CNT = 5'h10;
	localparam int HALF_DIV_DEFAULT = 8;
	// ----------------------------------------
	// Host APB map
	// ----------------------------------------
	localparam logic [7:0] HOST_CMD = 8'h00;
	localparam logic [7:0] HOST_STAT = 8'h04;
	localparam int CMD_CCC_BIT = 16;
	localparam int CMD_BADPAR_BIT = 17;
	typedef enum logic [1:0] {H_IDLE = 2'h0, H_LOW = 2'h1, H_HIGH = 2'h3, H_END = 2'h2} host_state_e;
endpackage

// ### rtl/sensor_link_if.sv
`timescale 1ns/10ps
interface sensor_link_if;
	logic link_clk;
	logic link_sel;
	logic link_mosi;
	logic link_miso;
	modport host(output link_clk, output link_sel, output link_mosi, input link_miso);
	modport device(input link_clk, input link_sel, input link_mosi, output link_miso);
endinterface

// ### rtl/sync2.sv
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// Two flops; the first is read by the second only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ### rtl/sensor_regs.sv
// Implementation choice: register access over APB.
`timescale 1ns/10ps
// How it works
// - X result split upper, middle, low nibble
// - Y result split the same way
// - Z result split the same way
// - Resolution masks invalid low result bits
// - Temperature is unsigned read-only byte
// - Period MSB selects one or two bytes
// - Sync period has forced zero LSB
// - Sync period counts measurements, not time
// - Period command 0x3F acts like low register
// - High period register used only when selected
// - Host writes zeros to high register top
// - Two-bit time unit picks 2^-11..2^-14
// - Time-unit command 0x9F sets the field
// - Host sync ticks reference measurement phase
// - Magnetic done flag set/clear conditions
// - Temperature done flag set/clear conditions
// - Motion flag set/clear conditions
// - Bad parity tick sets error, raises interrupt
// - Memory load done flag on successful load
// - Self-test flag follows self-test signal
// - Magnetic ready clears only on result read
// - Temperature ready clears only on read
module sensor_regs (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic CE,
	sensor_link_if.device LINK,
	input wire logic [magsense_pkg::AXIS_W-1:0] X_DATA,
	input wire logic [magsense_pkg::AXIS_W-1:0] Y_DATA,
	input wire logic [magsense_pkg::AXIS_W-1:0] Z_DATA,
	input wire logic [magsense_pkg::TEMP_W-1:0] T_DATA,
	input wire logic [1:0] RES_MODE,
	input wire logic MAG_DONE,
	input wire logic TEMP_DONE,
	input wire logic MOTION,
	input wire logic NEW_MEAS_CMD,
	input wire logic START_MDT_CMD,
	input wire logic MEM_LOAD_DONE,
	input wire logic MEM_RELOAD,
	input wire logic SELFTEST_SIG,
	input wire logic IBI_SENT,
	output logic [magsense_pkg::PERIOD_W-1:0] SYNC_PERIOD,
	output logic [3:0] SYNC_UNIT_EXP,
	output logic SYNC_TICK,
	output logic SYNC_DUE,
	output logic [7:0] DELAY_TIME,
	output logic DELAY_VALID,
	output logic IBI_REQ,
	output logic [magsense_pkg::STATUS_W-1:0] STATUS_FLAGS
);
	import magsense_pkg::*;
	// ----------------------------------------
	// Link capture
	// ----------------------------------------
	logic [2:0] pins_s;
	logic clk_prev_q, sel_prev_q;
	logic [CNT_W-1:0] bitcnt_q;
	logic [FRAME_BITS-1:0] frame_q;
	logic [7:0] rd_byte_q, out_sh_q;
	logic rd_frame_q, miso_q;
	sync2 #(.W(3)) pin_sync (
		.clk(MCLK),
		.rst_n(RESETN),
		.ce(CE),
		.d({LINK.link_clk, LINK.link_sel, LINK.link_mosi}),
		.q(pins_s)
	);
	wire lclk_s = pins_s[2];
	wire sel_s = pins_s[1];
	wire mosi_s = pins_s[0];
	wire rise = lclk_s & ~clk_prev_q & sel_s;
	wire fall = ~lclk_s & clk_prev_q & sel_s;
	wire sel_fall = ~sel_s & sel_prev_q;
	wire [FRAME_BITS-1:0] rx_next = {frame_q[FRAME_BITS-2:0], mosi_s};
	// Command byte complete: a read answers in the data byte slot
	wire cmd_edge = rise && (bitcnt_q == CMD_DONE_CNT - 5'h01);
	wire rd_stb = cmd_edge && !rx_next[8] && rx_next[7];
	wire [7:0] rd_addr = {1'b0, rx_next[6:0]};
	wire end_stb = sel_fall && (bitcnt_q == FRAME_END_CNT);
	wire f_ccc = frame_q[17];
	wire [7:0] f_cmd = frame_q[16:9];
	wire [7:0] f_data = frame_q[8:1];
	wire par_ok = ^frame_q;
	wire wr_stb = end_stb && !f_ccc && !f_cmd[7];
	wire ccc_stb = end_stb && f_ccc;
	wire tick_cmd = ccc_stb && (f_cmd == CCC_SYNC_TICK);
	wire dt_cmd = ccc_stb && (f_cmd == CCC_DELAY_TIME);
	wire sync_bad = (tick_cmd || dt_cmd) && !par_ok;
	// Frame shift and read-back shift; miso changes on falling link edges
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			clk_prev_q <= 1'b0;
			sel_prev_q <= 1'b0;
			bitcnt_q <= '0;
			frame_q <= '0;
			rd_frame_q <= 1'b0;
			out_sh_q <= '0;
			miso_q <= 1'b0;
		end else if (CE) begin
			clk_prev_q <= lclk_s;
			sel_prev_q <= sel_s;
			if (!sel_s) begin
				bitcnt_q <= '0;
				rd_frame_q <= 1'b0;
				miso_q <= 1'b0;
			end else if (rise) begin
				frame_q <= rx_next;
				bitcnt_q <= bitcnt_q + 5'h01;
				if (cmd_edge)
					rd_frame_q <= rd_stb;
			end else if (fall && rd_frame_q && bitcnt_q == CMD_DONE_CNT) begin
				miso_q <= rd_byte_q[7];
				out_sh_q <= {rd_byte_q[6:0], 1'b0};
			end else if (fall && rd_frame_q && bitcnt_q <= RD_LAST_CNT) begin
				miso_q <= out_sh_q[7];
				out_sh_q <= {out_sh_q[6:0], 1'b0};
			end else if (fall && rd_frame_q) begin
				miso_q <= 1'b0; // Back low after the slot, well before the frame closes
			end
		end
	end
	assign LINK.link_miso = miso_q;
	// ----------------------------------------
	// Result and setting registers
	// ----------------------------------------
	logic [AXIS_W-1:0] x_q, y_q, z_q;
	logic [TEMP_W-1:0] t_q;
	logic [7:0] period_low_q, period_high_q;
	logic [TU_W-1:0] tu_q;
	logic [STATUS_W-1:0] flags_q;
	// Keep only the bits meaningful at the active resolution
	function automatic logic [AXIS_W-1:0] res_mask(input logic [1:0] mode);
		case (mode)
			RES_16: res_mask = MASK_16BIT;
			RES_18: res_mask = MASK_18BIT;
			default: res_mask = MASK_20BIT;
		endcase
	endfunction
	// Read-back byte for a register address
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		case (a)
			REG_X_UPPER: reg_read = x_q[19:12];
			REG_X_MIDDLE: reg_read = x_q[11:4];
			REG_X_LOW_NIBBLE: reg_read = {x_q[3:0], 4'h0};
			REG_Y_UPPER: reg_read = y_q[19:12];
			REG_Y_MIDDLE: reg_read = y_q[11:4];
			REG_Y_LOW_NIBBLE: reg_read = {y_q[3:0], 4'h0};
			REG_Z_UPPER: reg_read = z_q[19:12];
			REG_Z_MIDDLE: reg_read = z_q[11:4];
			REG_Z_LOW_NIBBLE: reg_read = {z_q[3:0], 4'h0};
			REG_TEMPERATURE: reg_read = t_q;
			REG_STATUS_FIRST: reg_read = flags_q;
			default: reg_read = 8'h00; // Write-only and unmapped read zero
		endcase
	endfunction
	wire [AXIS_W-1:0] mask = res_mask(RES_MODE);
	wire wr_low = (wr_stb && f_cmd == REG_SYNC_PERIOD_LOW) || (ccc_stb && f_cmd == CCC_SYNC_PERIOD);
	wire wr_high = wr_stb && f_cmd == REG_SYNC_PERIOD_HIGH;
	wire wr_tu = (wr_stb && f_cmd == REG_SYNC_TIME_UNIT) || (ccc_stb && f_cmd == CCC_TIME_UNIT);
	// Results are captured whole at completion; axis results are masked by resolution, temperature is not
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			x_q <= '0;
			y_q <= '0;
			z_q <= '0;
			t_q <= '0;
			rd_byte_q <= '0;
		end else if (CE) begin
			if (MAG_DONE) begin
				x_q <= X_DATA & mask;
				y_q <= Y_DATA & mask;
				z_q <= Z_DATA & mask;
			end
			if (TEMP_DONE)
				t_q <= T_DATA;
			if (rd_stb)
				rd_byte_q <= reg_read(rd_addr);
		end
	end
	// Settings; the high byte is stored whole, only its low two bits matter
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			period_low_q <= '0;
			period_high_q <= '0;
			tu_q <= '0;
		end else if (CE) begin
			if (wr_low)
				period_low_q <= f_data;
			if (wr_high)
				period_high_q <= f_data;
			if (wr_tu)
				tu_q <= f_data[TU_W-1:0];
		end
	end
	// Width select picks one or two bytes; LSB always zero
	wire two_byte = period_low_q[PERIOD_WIDTH_SEL_BIT];
	wire [PERIOD_W-1:0] period_val = two_byte ? {period_high_q[1:0], period_low_q[6:0], 1'b0}
		: {2'b00, period_low_q[6:0], 1'b0};
	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	wire res_access = rd_stb && (rd_addr <= REG_Z_LOW_NIBBLE);
	wire temp_access = rd_stb && (rd_addr == REG_TEMPERATURE);
	wire stat_read = rd_stb && (rd_addr == REG_STATUS_FIRST);
	wire [STATUS_W-1:0] set_v, clr_v, flags_d;
	assign set_v[ST_MAG_DONE_INT] = MAG_DONE;
	assign clr_v[ST_MAG_DONE_INT] = NEW_MEAS_CMD | res_access | IBI_SENT | stat_read;
	assign set_v[ST_TEMP_DONE_INT] = TEMP_DONE;
	assign clr_v[ST_TEMP_DONE_INT] = NEW_MEAS_CMD | temp_access | IBI_SENT | stat_read;
	assign set_v[ST_MOTION_INT] = MOTION;
	assign clr_v[ST_MOTION_INT] = START_MDT_CMD | IBI_SENT | stat_read;
	assign set_v[ST_SYNC_ERR] = sync_bad;
	assign clr_v[ST_SYNC_ERR] = IBI_SENT;
	assign set_v[ST_MEM_LOAD_DONE] = MEM_LOAD_DONE;
	assign clr_v[ST_MEM_LOAD_DONE] = MEM_RELOAD;
	assign set_v[ST_SELFTEST] = SELFTEST_SIG;
	assign clr_v[ST_SELFTEST] = ~SELFTEST_SIG;
	assign set_v[ST_MAG_READY] = MAG_DONE;
	assign clr_v[ST_MAG_READY] = res_access;
	assign set_v[ST_TEMP_READY] = TEMP_DONE;
	assign clr_v[ST_TEMP_READY] = temp_access;

	// Same next-state form for every flag, so no event is lost to a clear
	genvar gi;
	generate
		for (gi = 0; gi < STATUS_W; gi++) begin : g_flag
			assign flags_d[gi] = set_v[gi] | (flags_q[gi] & ~clr_v[gi]);
		end
	endgenerate

	// ----------------------------------------
	// Synchronisation counting
	// ----------------------------------------
	logic [PERIOD_W-1:0] meas_cnt_q;
	wire [PERIOD_W-1:0] meas_cnt_inc = meas_cnt_q + 10'h001;
	wire period_hit = MAG_DONE && (period_val != '0) && (meas_cnt_inc >= period_val);

	// Sync tick realigns the count; period is in measurements, not time
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			meas_cnt_q <= '0;
			flags_q <= STATUS_RESET;
			SYNC_PERIOD <= '0;
			SYNC_UNIT_EXP <= TU_BASE_EXP;
			SYNC_TICK <= 1'b0;
			SYNC_DUE <= 1'b0;
			DELAY_TIME <= '0;
			DELAY_VALID <= 1'b0;
			IBI_REQ <= 1'b0;
			STATUS_FLAGS <= STATUS_RESET;
		end else if (CE) begin
			if (tick_cmd && par_ok)
				meas_cnt_q <= '0;
			else if (period_hit)
				meas_cnt_q <= '0;
			else if (MAG_DONE)
				meas_cnt_q <= meas_cnt_inc;
			flags_q <= flags_d;
			SYNC_PERIOD <= period_val;
			SYNC_UNIT_EXP <= TU_BASE_EXP + {2'b00, tu_q};
			SYNC_TICK <= tick_cmd && par_ok;
			SYNC_DUE <= period_hit;
			if (dt_cmd && par_ok)
				DELAY_TIME <= f_data;
			DELAY_VALID <= dt_cmd && par_ok;
			IBI_REQ <= flags_d[ST_SYNC_ERR];
			STATUS_FLAGS <= flags_d;
		end
	end
endmodule

// ### rtl/sensor_host.sv
`timescale 1ns/10ps
module sensor_host #(
	parameter int HALF_DIV = magsense_pkg::HALF_DIV_DEFAULT
) (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic CE,
	sensor_link_if.host LINK,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	import magsense_pkg::*;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	host_state_e state_q;
	logic [FRAME_BITS-1:0] tx_q;
	logic [CNT_W-1:0] idx_q;
	logic [15:0] div_q;
	logic [7:0] rdata_q;
	logic clk_q, sel_q, mosi_q;
	logic miso_s;

	wire busy = (state_q != H_IDLE);
	wire acc = PSEL && PENABLE;
	wire hit_cmd = PADDR == HOST_CMD;
	wire hit_stat = PADDR == HOST_STAT;
	wire start = acc && PWRITE && hit_cmd && !busy; // Busy writes are dropped
	wire [16:0] tx_body = {PWDATA[CMD_CCC_BIT], PWDATA[15:0]};
	// Odd parity over the frame; a test bit can spoil it on purpose
	wire tx_par = ~(^tx_body) ^ PWDATA[CMD_BADPAR_BIT];
	wire half_done = (div_q == 16'(HALF_DIV - 1));
	wire [31:0] rd_mux = hit_stat ? {16'h0000, rdata_q, 7'h00, busy} : 32'h00000000;

	sync2 #(.W(1)) miso_sync (
		.clk(MCLK),
		.rst_n(RESETN),
		.ce(CE),
		.d(LINK.link_miso),
		.q(miso_s)
	);

	// Zero-wait slave; unmapped addresses answer with an error
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			PRDATA <= '0;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else if (CE) begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !hit_cmd && !hit_stat;
			PRDATA <= rd_mux;
		end
	end

	// ----------------------------------------
	// Frame generator: link clock by division
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= H_IDLE;
			tx_q <= '0;
			idx_q <= '0;
			div_q <= '0;
			rdata_q <= '0;
			clk_q <= 1'b0;
			sel_q <= 1'b0;
			mosi_q <= 1'b0;
		end else if (CE) begin
			div_q <= half_done ? 16'h0000 : div_q + 16'h0001;
			case (state_q)
				H_IDLE: begin
					div_q <= '0;
					if (start) begin
						tx_q <= {tx_body[15:0], tx_par, 1'b0};
						mosi_q <= tx_body[16];
						sel_q <= 1'b1;
						idx_q <= '0;
						state_q <= H_LOW;
					end
				end
				H_LOW: if (half_done) begin
					clk_q <= 1'b1;
					state_q <= H_HIGH;
				end
				H_HIGH: if (half_done) begin
					// Sample late in the high phase; the device answers on falls
					if (idx_q >= CMD_DONE_CNT && idx_q <= RD_LAST_CNT)
						rdata_q <= {rdata_q[6:0], miso_s};
					clk_q <= 1'b0;
					if (idx_q == FRAME_END_CNT - 5'h01) begin
						state_q <= H_END;
					end else begin
						idx_q <= idx_q + 5'h01;
						mosi_q <= tx_q[FRAME_BITS-1];
						tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
						state_q <= H_LOW;
					end
				end
				H_END: if (half_done) begin
					sel_q <= 1'b0;
					mosi_q <= 1'b0;
					state_q <= H_IDLE;
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	assign LINK.link_clk = clk_q;
	assign LINK.link_sel = sel_q;
	assign LINK.link_mosi = mosi_q;
endmodule

// ### verification/magnetometer_result_sync_status_regs_asserts.sv
`timescale 1ns/10ps
module link_checker (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic link_clk,
	input wire logic link_sel,
	input wire logic link_mosi,
	input wire logic link_miso
);
	logic clk_q;
	logic [4:0] rise_q;
	wire rise_w = link_clk & ~clk_q;
	// Count link clock rises per frame; cleared whenever the frame is closed
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			clk_q <= 1'b0;
			rise_q <= 5'h00;
		end else begin
			clk_q <= link_clk;
			rise_q <= !link_sel ? 5'h00 : rise_q + {4'h0, rise_w};
		end
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	// Half periods are fixed at eight system clocks for the divider in use
	sequence high_phase;
		link_clk [*8] ##1 !link_clk;
	endsequence
	sequence low_phase;
		!link_clk [*8];
	endsequence
	chk_clock_idle_low: assert property (!link_sel |-> !link_clk)
		else $error("link clock moves outside a frame");
	chk_miso_idle_low: assert property (!link_sel |-> !link_miso)
		else $error("device data line not low outside a frame");
	chk_clock_high_time: assert property ($rose(link_clk) |-> high_phase)
		else $error("link clock high phase wrong length");
	chk_clock_low_time: assert property ($fell(link_clk) |-> low_phase)
		else $error("link clock low phase too short");
	chk_frame_first_rise: assert property ($rose(link_sel) |-> low_phase ##1 link_clk)
		else $error("first link clock rise misplaced");
	chk_frame_bit_count: assert property ($fell(link_sel) |-> rise_q == 5'h12)
		else $error("frame does not hold eighteen bits");
	chk_frame_gap_min: assert property ($fell(link_sel) |-> !link_sel [*4])
		else $error("frames too close together");
	chk_mosi_held_high: assert property (link_sel && link_clk |-> $stable(link_mosi))
		else $error("host data changed while link clock high");
	chk_miso_held_high: assert property (link_sel && link_clk |-> $stable(link_miso))
		else $error("device data changed while link clock high");
	cover property ($fell(link_sel));
endmodule

// ### verification/magnetometer_result_sync_status_regs_tb_top.sv
`timescale 1ns/10ps
module magnetometer_result_sync_status_regs_tb_top;
	import magsense_pkg::*;
	logic mclk, resetn, psel, penable, pwrite, pready, pslverr, selftest, tick, due, ibi_req, err, dvalid, ce;
	logic [7:0] paddr, ev, td, delay_t, status;
	logic [31:0] pwdata, prdata, rd;
	logic [19:0] xd, yd, zd;
	logic [1:0] res_mode;
	logic [9:0] period;
	logic [3:0] unit_exp;
	int failures, n_tests, cyc, n_tick, n_due, n_dv;
	sensor_link_if sensor_link_if_inst();
	sensor_regs sensor_regs_inst(.MCLK(mclk), .RESETN(resetn), .CE(ce), .LINK(sensor_link_if_inst.device),
		.X_DATA(xd), .Y_DATA(yd), .Z_DATA(zd), .T_DATA(td), .RES_MODE(res_mode), .MAG_DONE(ev[0]),
		.TEMP_DONE(ev[1]), .MOTION(ev[2]), .NEW_MEAS_CMD(ev[3]), .START_MDT_CMD(ev[4]), .MEM_LOAD_DONE(ev[5]),
		.MEM_RELOAD(ev[6]), .SELFTEST_SIG(selftest), .IBI_SENT(ev[7]), .SYNC_PERIOD(period),
		.SYNC_UNIT_EXP(unit_exp), .SYNC_TICK(tick), .SYNC_DUE(due), .DELAY_TIME(delay_t), .DELAY_VALID(dvalid),
		.IBI_REQ(ibi_req), .STATUS_FLAGS(status));
	sensor_host #(.HALF_DIV(HALF_DIV_DEFAULT)) sensor_host_inst(.MCLK(mclk), .RESETN(resetn), .CE(ce),
		.LINK(sensor_link_if_inst.host), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	link_checker link_checker_inst(.MCLK(mclk), .RESETN(resetn), .link_clk(sensor_link_if_inst.link_clk),
		.link_sel(sensor_link_if_inst.link_sel), .link_mosi(sensor_link_if_inst.link_mosi),
		.link_miso(sensor_link_if_inst.link_miso));
	// ----------------------------------------
	// Clock, pulse monitors and hang guard
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// A run of 33 frames needs well under this many cycles
	always @(posedge mclk) begin
		cyc++;
		if (tick === 1'b1) n_tick++;
		if (due === 1'b1) n_due++;
		if (dvalid === 1'b1) n_dv++;
		if (cyc == 60000) begin
			failures++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// Bus, link and compare tasks
	// ----------------------------------------
	task automatic wrap_up;
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t output %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Busy is polled so no command is dropped; writes land three clocks after the frame
	task automatic frame(input logic [17:0] w);
		apb(1'b1, HOST_CMD, {14'h0000, w});
		rd = 32'h00000001;
		while (rd[0] !== 1'b0) apb(1'b0, HOST_STAT, 32'h00000000);
		repeat (4) @(posedge mclk);
	endtask
	task automatic lw(input logic [7:0] a, input logic [7:0] d);
		frame({2'b00, 1'b0, a[6:0], d});
	endtask
	task automatic ccc(input logic [7:0] c, input logic [7:0] d, input logic bad);
		frame({bad, 1'b1, c, d});
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		frame({2'b00, 1'b1, a[6:0], 8'h00});
		n_tests++;
		if (rd[15:8] !== exp) begin
			failures++;
			$display("FAIL %0t reg %h read %h expected %h", $time, a, rd[15:8], exp);
		end
	endtask
	// One-cycle event pulses; the flags are settled by the following falling edge
	task automatic pulse(input logic [7:0] m);
		@(posedge mclk);
		ev <= m;
		@(posedge mclk);
		ev <= 8'h00;
		@(negedge mclk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_results;
		xd <= 20'hABCDE;
		yd <= 20'h12345;
		zd <= 20'h6789F;
		res_mode <= 2'h2;
		pulse(8'h01);
		chk_out(32'(status), 32'h00000041);
		chk_reg(REG_X_UPPER, 8'hAB);
		chk_out(32'(status), 32'h00000000);
		chk_reg(REG_X_MIDDLE, 8'hCD);
		chk_reg(REG_X_LOW_NIBBLE, 8'hE0);
		chk_reg(REG_Y_UPPER, 8'h12);
		chk_reg(REG_Y_MIDDLE, 8'h34);
		chk_reg(REG_Y_LOW_NIBBLE, 8'h50);
		chk_reg(REG_Z_UPPER, 8'h67);
		chk_reg(REG_Z_MIDDLE, 8'h89);
		chk_reg(REG_Z_LOW_NIBBLE, 8'hF0);
		lw(REG_X_UPPER, 8'h55);
		chk_reg(REG_X_UPPER, 8'hAB);
		res_mode <= 2'h0;
		pulse(8'h01);
		chk_reg(REG_X_LOW_NIBBLE, 8'h00);
		chk_reg(REG_X_MIDDLE, 8'hCD);
		res_mode <= 2'h1;
		pulse(8'h01);
		chk_reg(REG_Z_LOW_NIBBLE, 8'hC0);
	endtask
	task automatic t_temp;
		td <= 8'hC3;
		pulse(8'h03);
		chk_out(32'(status), 32'h000000C3);
		chk_reg(REG_Z_UPPER, 8'h67);
		chk_out(32'(status), 32'h00000082);
		chk_reg(REG_TEMPERATURE, 8'hC3);
		chk_out(32'(status), 32'h00000000);
	endtask
	task automatic t_period;
		lw(REG_SYNC_PERIOD_LOW, 8'h35);
		chk_out(32'(period), 32'h0000006A);
		lw(REG_SYNC_PERIOD_HIGH, 8'h03);
		chk_out(32'(period), 32'h0000006A);
		lw(REG_SYNC_PERIOD_LOW, 8'hB5);
		chk_out(32'(period), 32'h0000036A);
		ccc(CCC_SYNC_PERIOD, 8'h81, 1'b0);
		chk_out(32'(period), 32'h00000302);
		ccc(CCC_SYNC_PERIOD, 8'h02, 1'b0);
		chk_out(32'(period), 32'h00000004);
		n_due = 0;
		repeat (8) pulse(8'h01);
		chk_out(32'(n_due), 32'h00000002);
		chk_reg(REG_X_UPPER, 8'hAB);
	endtask
	task automatic t_unit;
		for (int i = 0; i < 4; i++) begin
			lw(REG_SYNC_TIME_UNIT, {6'h3F, i[1:0]});
			chk_out(32'(unit_exp), 32'(4'hB + i[3:0]));
		end
		ccc(CCC_TIME_UNIT, 8'h02, 1'b0);
		chk_out(32'(unit_exp), 32'h0000000D);
	endtask
	task automatic t_sync;
		n_tick = 0;
		n_dv = 0;
		ccc(CCC_SYNC_TICK, 8'h00, 1'b0);
		chk_out(32'(n_tick), 32'h00000001);
		ccc(CCC_DELAY_TIME, 8'h5A, 1'b0);
		chk_out(32'({ibi_req, delay_t}), 32'h0000005A);
		chk_out(32'(n_dv), 32'h00000001);
		ccc(CCC_SYNC_TICK, 8'h00, 1'b1);
		chk_out(32'({ibi_req, status}), 32'h00000108);
		pulse(8'h80);
		chk_out(32'({ibi_req, status}), 32'h00000000);
		ccc(CCC_DELAY_TIME, 8'h11, 1'b1);
		chk_out(32'({ibi_req, status}), 32'h00000108);
		chk_out(32'({n_dv[7:0], delay_t}), 32'h0000015A);
		pulse(8'h80);
		chk_out(32'(n_tick), 32'h00000001);
	endtask
	task automatic t_flags;
		pulse(8'h04);
		chk_out(32'(status), 32'h00000004);
		pulse(8'h10);
		chk_out(32'(status), 32'h00000000);
		pulse(8'h04);
		chk_reg(REG_STATUS_FIRST, 8'h04);
		chk_out(32'(status), 32'h00000000);
		pulse(8'h20);
		selftest <= 1'b1;
		pulse(8'h00);
		chk_out(32'(status), 32'h00000030);
		selftest <= 1'b0;
		pulse(8'h40);
		chk_out(32'(status), 32'h00000000);
		pulse(8'h03);
		pulse(8'h08);
		chk_out(32'(status), 32'h000000C0);
		pulse(8'h09);
		chk_out(32'(status), 32'h000000C1);
		pulse(8'h84);
		chk_out(32'(status), 32'h000000C4);
		// Clock enable low: a done pulse must leave every flag frozen
		ce <= 1'b0;
		pulse(8'h02);
		ce <= 1'b1;
		chk_out(32'(status), 32'h000000C4);
		apb(1'b0, 8'h08, 32'h00000000);
		chk_out({rd[30:0], err}, 32'h00000001);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{resetn, psel, penable, pwrite, selftest, ce} = 6'h01;
		{paddr, ev, td, pwdata, xd, yd, zd, res_mode} = '0;
		{failures, n_tests, cyc, n_tick, n_due, n_dv} = '0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
		chk_out(32'({unit_exp, status}), 32'h00000B00);
		chk_reg(REG_STATUS_FIRST, 8'h00);
		t_results();
		t_temp();
		t_period();
		t_unit();
		t_sync();
		t_flags();
		wrap_up();
	end
endmodule
